// ### sim/c2c_cursor_regs_chk.sv
/*
  port checks for the second cursor bank.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module c2c_cursor_regs_chk (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // host i/o
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rvalid_o,
  // cursor outputs
  input wire logic cursor_enable_o,
  input wire logic [2:0] cursor_mode_o,
  input wire logic [10:0] height_lines_o,
  input wire logic [21:0] base_offset_o,
  input wire logic [3:0] pattern_sel_o,
  input wire logic [21:0] fetch_addr_o,
  input wire logic [11:0] xpos_o
);
  logic [7:0] idx;
  logic [3:0] sh;
  logic dw;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // shadow of the index port
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      idx <= 8'h00;
    end else if (io_wr_i && io_addr_i == 16'h03d6) begin
      idx <= io_wdata_i;
    end
  end
  // data port write and pattern size shift of the mode
  assign dw = io_wr_i && io_addr_i == 16'h03d7;
  assign sh = cursor_mode_o inside {3'h2, 3'h3} ? 4'hb : cursor_mode_o inside {[3'h4:3'h6]} ? 4'ha : 4'h8;
  a_enable_mode: assert property (cursor_enable_o == (cursor_mode_o inside {[3'h1:3'h6]}))
    else $error("enable wrong");
  a_reset_clear: assert property ($fell(reset_i) |-> cursor_mode_o == 3'h0 && !io_rvalid_o)
    else $error("not cleared");
  a_base_align: assert property (base_offset_o[11:0] == 12'h000)
    else $error("base unaligned");
  a_fetch_sum: assert property (fetch_addr_o == 22'(base_offset_o + (22'(pattern_sel_o) << sh)))
    else $error("fetch wrong");
  a_height_quad: assert property (height_lines_o[1:0] == 2'h0)
    else $error("height odd");
  a_xpos_low: assert property (dw && idx == 8'hac |-> ##2 xpos_o[7:0] == $past(io_wdata_i, 2))
    else $error("xpos low wrong");
  a_xpos_high: assert property (dw && idx == 8'had |-> ##2 {xpos_o[11], 4'h0, xpos_o[10:8]} == ($past(io_wdata_i, 2) & 8'h87))
    else $error("xpos high wrong");
  a_resv_read: assert property (io_rd_i && io_addr_i == 16'h03d7 && idx == 8'hab |=> io_rdata_o[7:6] == 2'h0)
    else $error("reserved set");
endmodule
bind c2c_cursor_regs c2c_cursor_regs_chk u_chk (.*);

// ### sim/c2c_cursor_regs_tb.sv
/*
  random and corner writes to the second cursor bank, with readback and output checks.
  assumes the bank and its checker are compiled first.
*/
`timescale 1ns/10ps
module c2c_cursor_regs_tb;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] io_addr_i = 16'h0000;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o, v;
  logic io_rvalid_o, cursor_enable_o, blink_en_o, vstretch_o, hstretch_o, origin_sel_o;
  logic [2:0] cursor_mode_o;
  logic [10:0] height_lines_o;
  logic [21:0] base_offset_o, fetch_addr_o;
  logic [3:0] pattern_sel_o;
  logic [11:0] xpos_o, ypos_o;
  logic [7:0] m [8] = '{default: 8'h00};
  int miscompares = 0;
  int checked = 0;
  int seed = 32'ha329;
  int i;
  c2c_cursor_regs u_dut (.*);
  // 40 MHz clock
  always #12.5 core_clk_i = ~core_clk_i;
  // compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one access; strobe stands one cycle, next call or idle replaces it
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
    io_addr_i = a;
    io_wr_i = w;
    io_rd_i = !w;
    io_wdata_i = d;
    @(negedge core_clk_i);
  endtask
  task automatic wreg(input logic [7:0] x, input logic [7:0] d);
    io(16'h03d6, 1'b1, x);
    io(16'h03d7, 1'b1, d);
  endtask
  // the answer shows one cycle after the strobe
  task automatic rd(input logic [7:0] x, input logic [7:0] e);
    io(16'h03d6, 1'b1, x);
    io(16'h03d7, 1'b0, 8'h00);
    chk("rvalid", io_rvalid_o, 1);
    chk("rdata", io_rdata_o, e);
  endtask
  // height in lines and pattern size shift expected from the mirror
  function automatic logic [10:0] hgt();
    if (m[0][3])
      return 11'((m[1] + 9'h1) * 4);
    return m[0][2:0] == 3'h1 ? 11'h20 : m[0][2:0] inside {3'h2, 3'h3} ? 11'h80 : m[0][2:0] inside {[3'h4:3'h6]} ? 11'h40 : 11'h0;
  endfunction
  function automatic int sh();
    return m[0][2:0] inside {3'h2, 3'h3} ? 11 : m[0][2:0] inside {[3'h4:3'h6]} ? 10 : 8;
  endfunction
  // read every register back, then every derived output
  task automatic chkall();
    for (int k = 0; k < 8; k++)
      rd(8'ha8 + 8'(k), m[k]);
    chk("mode", cursor_mode_o, m[0][2:0]);
    chk("en", cursor_enable_o, m[0][2:0] != 3'h0 && m[0][2:0] != 3'h7);
    chk("ctl", {blink_en_o, vstretch_o, hstretch_o, origin_sel_o}, m[0][7:4]);
    chk("hgt", height_lines_o, hgt());
    chk("base", base_offset_o, {m[3][5:0], m[2][7:4], 12'h000});
    chk("pat", pattern_sel_o, m[2][3:0]);
    chk("fetch", fetch_addr_o, 22'({m[3][5:0], m[2][7:4], 12'h000} + (22'(m[2][3:0]) << sh())));
    chk("x", xpos_o, {m[5][7], m[5][2:0], m[4]});
    chk("y", ypos_o, {m[7][7], m[7][2:0], m[6]});
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // all modes first, then tallest height, full base high, unmapped index, random
  initial begin
    repeat (12) @(negedge core_clk_i);
    reset_i = 1'b0;
    chkall();
    for (int j = 0; j < 60; j++) begin
      i = $random(seed) & 7;
      v = 8'($random(seed));
      if (j < 8) begin
        i = 0;
        v[2:0] = 3'(j);
        v[3] = 1'(j == 7); // implied heights first, then the extension
      end
      if (j == 8 || j == 9) begin
        i = j == 8 ? 1 : 3;
        v = 8'hff;
      end
      if (j == 10) begin
        wreg(8'hb0, v);
        rd(8'hb0, 8'h00);
        io(16'h03d6, 1'b0, 8'h00);
        chk("index", io_rdata_o, 8'hb0);
      end
      if (i == 2)
        v[3:0] = v[3:0] & 4'(15 >> (sh() - 8));
      m[i] = v & (i == 3 ? 8'h3f : i == 5 || i == 7 ? 8'h87 : 8'hff);
      wreg(8'ha8 + 8'(i), v);
      chkall();
    end
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    reset_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    reset_i = 1'b0;
    m = '{default: 8'h00};
    chkall();
    tally_and_finish();
  end
  // traffic needs about 1100 cycles
  initial begin
    repeat (5000) @(posedge core_clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule

// ### verilog/c2c_cursor_regs.sv
/*
  second cursor configuration bank behind an index/data i/o pair,
  with the assembled values for the cursor display pipeline.
  assumes the host i/o strobes are single-cycle and on core_clk_i.
*/
`timescale 1ns/10ps
// Overview of operation
// R1: with height extension on, cursor height comes from the 8-bit height field.
// R2: software loads lines/4 minus 1; shown height is (field+1)*4 lines.
// R3: pattern space is a 22-bit offset; base low bits 7-4 give offset 15-12.
// R4: base high bits 5-0 give offset bits 21-16.
// R5: base low bits 3-0 select one of up to 16 patterns.
// R6: software picks only patterns that fit in the 4KB space.
// R7: horizontal position is 12-bit; magnitude 7-0 from x low register.
// R8: x high bit 7 is sign, bits 2-0 magnitude 10-8, sign-magnitude.
// R9: vertical position is 12-bit; magnitude 7-0 from y low register.
// R10: y high bit 7 is sign, bits 2-0 magnitude 10-8.
// R11: reserved bits of base high and position high registers read zero.
// R12: mode 000 disables the cursor and is the reset value; 111 reserved.
// R13: control bit 3 makes height come from the height register.
// R14: offset bits 11-0 are zero, aligning the space to 4KB.
// R15: fetch address is base plus pattern index times pattern size.
module c2c_cursor_regs (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // host i/o access
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  // cursor control to the display pipeline
  output logic cursor_enable_o,
  output logic [2:0] cursor_mode_o,
  output logic blink_en_o,
  output logic vstretch_o,
  output logic hstretch_o,
  output logic origin_sel_o,
  // cursor geometry to the display pipeline
  output logic [10:0] height_lines_o,
  output logic [21:0] base_offset_o,
  output logic [3:0] pattern_sel_o,
  output logic [21:0] fetch_addr_o,
  output logic [11:0] xpos_o,
  output logic [11:0] ypos_o
);
  import c2c_pkg::*;

  // registered state and its next value
  c2c_state_s st;
  c2c_state_s next_st;
  // stored register values, indexed from the control register upward
  logic [7:0] reg_val [C2C_NREG];
  // host access decode
  logic data_hit;
  logic index_hit;
  logic data_wr;
  logic data_rd;
  logic index_wr;
  logic index_rd;
  // read selection from the current index
  logic [7:0] sel_val;
  logic sel_ok;
  // derived cursor geometry
  logic [10:0] ext_lines;
  logic [10:0] mode_lines;
  logic [3:0] pat_shift;
  logic [21:0] base_full;
  logic [21:0] pat_offset;
  logic [11:0] xpos_full;
  logic [11:0] ypos_full;

  // one store per register; reserved bits are masked off at write
  generate
    for (genvar i = 0; i < C2C_NREG; i++) begin : g_reg
      c2c_reg_if rif ();
      assign rif.wr_en = data_wr && (st.index == C2C_IDX_CONTROL + 8'(i));
      assign rif.wdata = io_wdata_i;
      assign reg_val[i] = rif.value;
      c2c_reg8 #(
        .WMASK(C2C_WMASK[i]) // R11
      ) u_reg (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .reg_if(rif)
      );
    end
  endgenerate

  // port decode; any other address is ignored
  assign data_hit = (io_addr_i == C2C_DATA_PORT);
  assign index_hit = (io_addr_i == C2C_INDEX_PORT);
  assign data_wr = io_wr_i && data_hit;
  assign data_rd = io_rd_i && data_hit;
  assign index_wr = io_wr_i && index_hit;
  assign index_rd = io_rd_i && index_hit;

  // read selection from the current index; unmapped indices read zero
  always_comb begin
    sel_ok = (st.index >= C2C_IDX_CONTROL) && (st.index <= C2C_IDX_YPOS_HIGH);
    sel_val = 8'h00;
    for (int i = 0; i < C2C_NREG; i++) begin
      if (st.index == C2C_IDX_CONTROL + 8'(i)) begin
        sel_val = reg_val[i];
      end
    end
  end

  // height and pattern size implied by the mode; extension overrides the height
  always_comb begin
    ext_lines = 11'(({3'h0, reg_val[1]} + 11'h001) << C2C_HEIGHT_UNIT_LOG2); // R2
    mode_lines = 11'h000;
    pat_shift = C2C_SHIFT_32;
    unique case (reg_val[0][2:0])
      // cursor off: no implied height
      C2C_MODE_OFF: begin
        mode_lines = 11'h000;
        pat_shift = C2C_SHIFT_32;
      end
      // 32x32 two-plane patterns of 256 bytes
      C2C_MODE_32_ANDXOR: begin
        mode_lines = C2C_HEIGHT_32;
        pat_shift = C2C_SHIFT_32;
      end
      // 128x128 two-colour patterns of 2KB
      C2C_MODE_128_2COL: begin
        mode_lines = C2C_HEIGHT_128;
        pat_shift = C2C_SHIFT_128;
      end
      // 128x128 one colour with transparency, 2KB patterns
      C2C_MODE_128_1COL: begin
        mode_lines = C2C_HEIGHT_128;
        pat_shift = C2C_SHIFT_128;
      end
      // 64x64 three colours with transparency, 1KB patterns
      C2C_MODE_64_3COL: begin
        mode_lines = C2C_HEIGHT_64;
        pat_shift = C2C_SHIFT_64;
      end
      // 64x64 two-plane patterns of 1KB
      C2C_MODE_64_ANDXOR: begin
        mode_lines = C2C_HEIGHT_64;
        pat_shift = C2C_SHIFT_64;
      end
      // 64x64 four-colour patterns of 1KB
      C2C_MODE_64_4COL: begin
        mode_lines = C2C_HEIGHT_64;
        pat_shift = C2C_SHIFT_64;
      end
      // reserved code behaves as off, so a stray write never shows a cursor
      C2C_MODE_RSVD: begin
        mode_lines = 11'h000;
        pat_shift = C2C_SHIFT_32;
      end
    endcase
  end

  // aligned base, pattern offset within the space and signed positions
  always_comb begin
    base_full = {reg_val[3][5:0], reg_val[2][7:4], 12'h000}; // R3 R4 R14
    pat_offset = 22'({18'h00000, reg_val[2][3:0]} << pat_shift); // R15
    xpos_full = {reg_val[5][C2C_POS_SIGN_BIT], reg_val[5][2:0], reg_val[4]}; // R7 R8
    ypos_full = {reg_val[7][C2C_POS_SIGN_BIT], reg_val[7][2:0], reg_val[6]}; // R9 R10
  end

  // next state: index, read answer and registered outputs
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    // index port write and the read answer of either port
    if (index_wr) begin
      next_st.index = io_wdata_i;
    end
    if (index_rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = st.index;
    end else if (data_rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = sel_ok ? sel_val : 8'h00; // R11
    end
    // control fields, registered once more on their way out
    next_st.mode = reg_val[0][2:0];
    next_st.enable = (reg_val[0][2:0] != C2C_MODE_OFF) && (reg_val[0][2:0] != C2C_MODE_RSVD); // R12
    next_st.blink = reg_val[0][C2C_CTRL_BLINK_BIT];
    next_st.vstretch = reg_val[0][C2C_CTRL_VSTRETCH_BIT];
    next_st.hstretch = reg_val[0][C2C_CTRL_HSTRETCH_BIT];
    next_st.origin = reg_val[0][C2C_CTRL_ORIGIN_BIT];
    // geometry and position, assembled from the separate bytes and registered once more on their way out
    next_st.height = reg_val[0][C2C_CTRL_VEXT_BIT] ? ext_lines : mode_lines; // R1 R13
    next_st.base = base_full; // R3 R4
    next_st.pattern = reg_val[2][3:0]; // R5
    next_st.fetch = 22'(base_full + pat_offset); // R15
    next_st.xpos = xpos_full; // R7 R8
    next_st.ypos = ypos_full; // R9 R10
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // read answer straight from state
  assign io_rdata_o = st.rdata;
  assign io_rvalid_o = st.rvalid;
  // control to the display pipeline
  assign cursor_enable_o = st.enable;
  assign cursor_mode_o = st.mode;
  assign blink_en_o = st.blink;
  assign vstretch_o = st.vstretch;
  assign hstretch_o = st.hstretch;
  assign origin_sel_o = st.origin;
  // geometry to the display pipeline
  assign height_lines_o = st.height;
  assign base_offset_o = st.base;
  assign pattern_sel_o = st.pattern;
  assign fetch_addr_o = st.fetch;
  assign xpos_o = st.xpos;
  assign ypos_o = st.ypos;
endmodule

// ### verilog/c2c_pkg.sv
/*
  constants and types for the second cursor configuration bank.
  assumes the host i/o path and the bank share core_clk_i.
*/
package c2c_pkg;
  // i/o ports of the index/data pair
  localparam logic [15:0] C2C_INDEX_PORT = 16'h03d6;
  localparam logic [15:0] C2C_DATA_PORT = 16'h03d7;
  // register indices behind the data port
  localparam logic [7:0] C2C_IDX_CONTROL = 8'ha8;
  localparam logic [7:0] C2C_IDX_HEIGHT = 8'ha9;
  localparam logic [7:0] C2C_IDX_BASE_LOW = 8'haa;
  localparam logic [7:0] C2C_IDX_BASE_HIGH = 8'hab;
  localparam logic [7:0] C2C_IDX_XPOS_LOW = 8'hac;
  localparam logic [7:0] C2C_IDX_XPOS_HIGH = 8'had;
  localparam logic [7:0] C2C_IDX_YPOS_LOW = 8'hae;
  localparam logic [7:0] C2C_IDX_YPOS_HIGH = 8'haf;
  localparam int C2C_NREG = 8;
  // writable bits per register, in index order from control upward
  localparam logic [7:0] C2C_WMASK [C2C_NREG] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h87, 8'hff, 8'h87};
  // value after reset of every register and of the index
  localparam logic [7:0] C2C_RESET_VALUE = 8'h00;
  // control register fields
  localparam int C2C_CTRL_BLINK_BIT = 7;
  localparam int C2C_CTRL_VSTRETCH_BIT = 6;
  localparam int C2C_CTRL_HSTRETCH_BIT = 5;
  localparam int C2C_CTRL_ORIGIN_BIT = 4;
  localparam int C2C_CTRL_VEXT_BIT = 3;
  // position high register fields
  localparam int C2C_POS_SIGN_BIT = 7;
  // cursor mode codes
  localparam logic [2:0] C2C_MODE_OFF = 3'h0;
  localparam logic [2:0] C2C_MODE_32_ANDXOR = 3'h1;
  localparam logic [2:0] C2C_MODE_128_2COL = 3'h2;
  localparam logic [2:0] C2C_MODE_128_1COL = 3'h3;
  localparam logic [2:0] C2C_MODE_64_3COL = 3'h4;
  localparam logic [2:0] C2C_MODE_64_ANDXOR = 3'h5;
  localparam logic [2:0] C2C_MODE_64_4COL = 3'h6;
  localparam logic [2:0] C2C_MODE_RSVD = 3'h7;
  // implied heights and log2 of pattern size in bytes per mode size class
  localparam logic [10:0] C2C_HEIGHT_32 = 11'h020;
  localparam logic [10:0] C2C_HEIGHT_64 = 11'h040;
  localparam logic [10:0] C2C_HEIGHT_128 = 11'h080;
  localparam logic [3:0] C2C_SHIFT_32 = 4'h8;
  localparam logic [3:0] C2C_SHIFT_64 = 4'ha;
  localparam logic [3:0] C2C_SHIFT_128 = 4'hb;
  // height field is lines divided by four, minus one
  localparam int C2C_HEIGHT_UNIT_LOG2 = 2;

  typedef struct packed {
    logic [7:0] value;
  } c2c_reg_s;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] rdata;
    logic rvalid;
    logic enable;
    logic [2:0] mode;
    logic blink;
    logic vstretch;
    logic hstretch;
    logic origin;
    logic [10:0] height;
    logic [21:0] base;
    logic [3:0] pattern;
    logic [21:0] fetch;
    logic [11:0] xpos;
    logic [11:0] ypos;
  } c2c_state_s;
endpackage

// ### verilog/c2c_reg8.sv
/*
  one 8-bit configuration register with a mask of writable bits.
  assumes the strobe is a one-cycle pulse on core_clk_i.
*/
`timescale 1ns/10ps
module c2c_reg8 #(
  parameter logic [7:0] WMASK = 8'hff
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register port
  c2c_reg_if.store reg_if
);
  import c2c_pkg::*;

  c2c_reg_s st;
  c2c_reg_s next_st;

  // masked bits never store a one, so they read back as zero
  always_comb begin
    next_st = st;
    if (reg_if.wr_en) begin
      next_st.value = reg_if.wdata & WMASK;
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st.value <= C2C_RESET_VALUE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_if.value = st.value;
endmodule

// ### verilog/c2c_reg_if.sv
/*
  write strobe, write data and stored value of one configuration register.
  assumes one driver per side: the bank drives the strobe, the store the value.
*/
`timescale 1ns/10ps
interface c2c_reg_if;
  logic wr_en;
  logic [7:0] wdata;
  logic [7:0] value;
  modport ctrl (output wr_en, output wdata, input value);
  modport store (input wr_en, input wdata, output value);
endinterface
